// >>> hw/picr_pkg.sv
// constants and types shared by the per-port ingress control register bank
package picr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PORT_MAX = 3;
    localparam int INDEX_W = 4;
    localparam int ENTRY_BYTES = 16;
    localparam int PRIO_W = 3;
    localparam int NUM_SRC = 5;

    // address layout: bits 15:12 hold the port number, bits 11:0 the offset
    localparam int PORT_FIELD_LSB = 12;
    localparam logic [11:0] OFF_ACL_BE_LSB = 12'h611;
    localparam logic [11:0] OFF_ACL_CTRL = 12'h612;
    localparam logic [11:0] OFF_MIRROR = 12'h800;
    localparam logic [11:0] OFF_PRIO = 12'h801;

    // access control byte
    localparam int ACL_WR_DONE_BIT = 6;
    localparam int ACL_RD_DONE_BIT = 5;
    localparam int ACL_DIR_BIT = 4;
    localparam logic [7:0] ACL_CTRL_RST = 8'h60;

    // mirroring control byte
    localparam int MIR_RX_BIT = 6;
    localparam int MIR_TX_BIT = 5;
    localparam int MIR_SNIFFER_BIT = 1;
    localparam logic [7:0] MIRROR_MASK = 8'h62;
    localparam logic [7:0] MIRROR_RST = 8'h00;

    // priority control byte; bits 4:0 also index the candidate vector
    localparam int PRI_HIGHEST_BIT = 7;
    localparam int PRI_OR_BIT = 6;
    localparam int PRI_MAC_BIT = 4;
    localparam int PRI_VLAN_BIT = 3;
    localparam int PRI_PCP_BIT = 2;
    localparam int PRI_DSCP_BIT = 1;
    localparam int PRI_ACL_BIT = 0;
    localparam logic [7:0] PRIO_MASK = 8'hDF;
    localparam logic [7:0] PRIO_RST = 8'h00;

    typedef enum logic [1:0] {
        PICR_IDLE,
        PICR_ACCESS,
        PICR_FINISH
    } picr_state_t;
endpackage : picr_pkg

// >>> hw/picr_entry_mem.sv
// entry store for the access-control-list tables, byte-writable, registered read
`timescale 1ns/100ps
`default_nettype none
module picr_entry_mem #(
    parameter int DATA_W = 128,
    parameter int DEPTH = 48,
    parameter int AW = 6
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [AW-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [DATA_W/8-1:0] byteEn,
    output logic [DATA_W-1:0] rdData
);
    typedef struct packed {
        logic [DATA_W-1:0] rdData;
    } picr_mem_state_t;

    picr_mem_state_t cur_ff;
    picr_mem_state_t nxt_cur;
    logic [DATA_W-1:0] store [DEPTH];

    if (DATA_W % 8 != 0 || DEPTH < 1 || (1 << AW) < DEPTH) begin : g_check
        $error("picr_entry_mem: bad geometry");
    end

    always_comb begin
        nxt_cur = cur_ff;
        if (rdEn) begin
            nxt_cur.rdData = store[addr];
        end
    end

    // array kept outside the struct: no reset, entries are undefined until written
    always_ff @(posedge sys_clk) begin
        if (ce && wrEn) begin
            for (int b = 0; b < DATA_W / 8; b++) begin
                if (byteEn[b]) begin
                    store[addr][b*8 +: 8] <= wrData[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur_ff <= '0;
        end else if (ce) begin
            cur_ff <= nxt_cur;
        end
    end

    assign rdData = cur_ff.rdData;
endmodule : picr_entry_mem
`default_nettype wire

// >>> hw/picr_regs.sv
// per-port ACL access, mirroring and priority classification control registers
`timescale 1ns/100ps
`default_nettype none
module picr_regs
    import picr_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int ENTRIES = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [picr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [picr_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [picr_pkg::DATA_W-1:0] regRdData,
    input wire logic [7:0] aclByteEnHi,
    input wire logic [picr_pkg::ENTRY_BYTES*8-1:0] aclStageData,
    output logic [picr_pkg::ENTRY_BYTES*8-1:0] aclEntryRdData,
    output logic [picr_pkg::ENTRY_BYTES-1:0] aclEntryRdByteEn,
    output logic aclEntryRdValid,
    output logic aclBusy,
    output logic [NUM_PORTS-1:0] rxSniffEn,
    output logic [NUM_PORTS-1:0] txSniffEn,
    output logic [NUM_PORTS-1:0] snifferPort,
    output logic [NUM_PORTS-1:0] prioHighestEn,
    output logic [NUM_PORTS-1:0] prioOrEn,
    output logic [NUM_PORTS-1:0] macPrioEn,
    output logic [NUM_PORTS-1:0] vlanPrioEn,
    output logic [NUM_PORTS-1:0] pcpPrioEn,
    output logic [NUM_PORTS-1:0] dscpPrioEn,
    output logic [NUM_PORTS-1:0] aclPrioEn,
    input wire logic pktValid,
    input wire logic [1:0] pktPort,
    input wire logic [picr_pkg::NUM_SRC-1:0] pktHit,
    input wire logic [picr_pkg::NUM_SRC-1:0][picr_pkg::PRIO_W-1:0] pktCandPrio,
    input wire logic [picr_pkg::PRIO_W-1:0] pktDefPrio,
    output logic pktPrioValid,
    output logic [picr_pkg::PRIO_W-1:0] pktPrio,
    output logic pktMonitor,
    input wire logic txValid,
    input wire logic [1:0] txPort,
    output logic txMonitor
);
    import picr_pkg::*;

    localparam int AW = $clog2(NUM_PORTS) + INDEX_W;
    localparam int DEPTH = NUM_PORTS * ENTRIES;
    localparam int EW = ENTRY_BYTES * 8;

    if (NUM_PORTS < 1 || NUM_PORTS > PORT_MAX) begin : g_check_ports
        $error("picr_regs: NUM_PORTS must be 1..3");
    end
    // the index field is four bits wide, so a port copy holds exactly 16 entries
    if (ENTRIES != (1 << INDEX_W)) begin : g_check_entries
        $error("picr_regs: ENTRIES must be 16");
    end

    typedef struct packed {
        picr_state_t state;
        logic [1:0] opPort;
        logic opWrite;
        logic [INDEX_W-1:0] opIndex;
        logic [ENTRY_BYTES-1:0] opByteEn;
        logic [NUM_PORTS-1:0][INDEX_W:0] aclCfg;
        logic [NUM_PORTS-1:0] wrDone;
        logic [NUM_PORTS-1:0] rdDone;
        logic [NUM_PORTS-1:0][7:0] mirror;
        logic [NUM_PORTS-1:0][7:0] prio;
        logic [DATA_W-1:0] rdData;
        logic [EW-1:0] entryRdData;
        logic [ENTRY_BYTES-1:0] entryRdByteEn;
        logic entryRdValid;
        logic prioValid;
        logic [PRIO_W-1:0] prioOut;
        logic monitor;
        logic txMon;
    } picr_regs_state_t;

    picr_regs_state_t cur_ff;
    picr_regs_state_t nxt_cur;
    logic [EW-1:0] memRdData;
    logic memWrEn;
    logic memRdEn;
    logic [AW-1:0] memAddr;
    logic regHit;
    logic [1:0] regPortIdx;
    logic pktHitPort;
    logic [1:0] pktIdx;
    logic txHitPort;
    logic [1:0] txIdx;

    ////////////////////////////////////////////////////////////////////////////
    // decoding and priority resolution

    // port number 1..NUM_PORTS to a zero-based copy index
    function automatic logic [2:0] portIndex(input logic [3:0] portNum);
        logic [3:0] idx;
        idx = portNum - 4'h1;
        if (portNum != 4'h0 && portNum <= 4'(NUM_PORTS)) begin
            portIndex = {1'b1, idx[1:0]};
        end else begin
            portIndex = 3'h0;
        end
    endfunction : portIndex

    function automatic logic [PRIO_W-1:0] resolvePrio(
        input logic [NUM_SRC-1:0] avail,
        input logic [NUM_SRC-1:0][PRIO_W-1:0] cand,
        input logic highest,
        input logic orMode,
        input logic [PRIO_W-1:0] defPrio
    );
        logic [PRIO_W-1:0] r;
        logic any;
        r = '0;
        any = 1'b0;
        // or wins over highest when both are set; software should set only one
        for (int i = 0; i < NUM_SRC; i++) begin
            if (avail[i]) begin
                if (orMode) begin
                    r = r | cand[i];
                end else if (highest) begin
                    if (!any || cand[i] > r) begin
                        r = cand[i];
                    end
                end else if (!any) begin
                    r = cand[i];
                end
                any = 1'b1;
            end
        end
        resolvePrio = any ? r : defPrio;
    endfunction : resolvePrio

    assign {regHit, regPortIdx} = portIndex(regAddr[ADDR_W-1:PORT_FIELD_LSB]);
    assign {pktHitPort, pktIdx} = portIndex({2'h0, pktPort});
    assign {txHitPort, txIdx} = portIndex({2'h0, txPort});

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [11:0] off;
        logic [7:0] pr;
        logic [NUM_SRC-1:0] avail;
        off = regAddr[PORT_FIELD_LSB-1:0];
        pr = '0;
        avail = '0;
        nxt_cur = cur_ff;
        nxt_cur.rdData = '0;
        nxt_cur.entryRdValid = 1'b0;
        nxt_cur.prioValid = 1'b0;

        // register reads: data stands only in the cycle after the strobe
        if (regRdStb && regHit) begin
            // status bits are rebuilt here, never stored as written
            case (off)
                OFF_ACL_CTRL: begin
                    nxt_cur.rdData = {1'b0, cur_ff.wrDone[regPortIdx],
                        cur_ff.rdDone[regPortIdx], cur_ff.aclCfg[regPortIdx]};
                end
                OFF_MIRROR: begin
                    nxt_cur.rdData = cur_ff.mirror[regPortIdx];
                end
                OFF_PRIO: begin
                    nxt_cur.rdData = cur_ff.prio[regPortIdx];
                end
                default: begin
                    nxt_cur.rdData = '0;
                end
            endcase
        end

        // register writes; read-only and reserved bits are masked off
        if (regWrStb && regHit) begin
            case (off)
                OFF_ACL_CTRL: begin
                    nxt_cur.aclCfg[regPortIdx] = regWrData[INDEX_W:0];
                end
                OFF_MIRROR: begin
                    nxt_cur.mirror[regPortIdx] = regWrData & MIRROR_MASK;
                end
                OFF_PRIO: begin
                    nxt_cur.prio[regPortIdx] = regWrData & PRIO_MASK;
                end
                // the enable byte itself is kept outside; a read of it returns 0
                OFF_ACL_BE_LSB: begin
                    // a start while a transfer runs is dropped, so no flag can
                    // be cleared and set in the same cycle
                    if (cur_ff.state == PICR_IDLE) begin
                        nxt_cur.state = PICR_ACCESS;
                        nxt_cur.opPort = regPortIdx;
                        nxt_cur.opWrite = cur_ff.aclCfg[regPortIdx][ACL_DIR_BIT];
                        nxt_cur.opIndex = cur_ff.aclCfg[regPortIdx][INDEX_W-1:0];
                        nxt_cur.opByteEn = {aclByteEnHi, regWrData};
                        if (cur_ff.aclCfg[regPortIdx][ACL_DIR_BIT]) begin
                            nxt_cur.wrDone[regPortIdx] = 1'b0;
                        end else begin
                            nxt_cur.rdDone[regPortIdx] = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // entry transfer sequencer: access then finish, a fixed two cycles
        // set and clear never meet, since a start is only taken when idle
        case (cur_ff.state)
            PICR_IDLE: begin
            end
            PICR_ACCESS: begin
                nxt_cur.state = PICR_FINISH;
            end
            PICR_FINISH: begin
                nxt_cur.state = PICR_IDLE;
                if (cur_ff.opWrite) begin
                    nxt_cur.wrDone[cur_ff.opPort] = 1'b1;
                end else begin
                    nxt_cur.rdDone[cur_ff.opPort] = 1'b1;
                    nxt_cur.entryRdData = memRdData;
                    nxt_cur.entryRdByteEn = cur_ff.opByteEn;
                    nxt_cur.entryRdValid = 1'b1;
                end
            end
            default: begin
                nxt_cur.state = PICR_IDLE;
            end
        endcase

        // ingress priority classification per packet
        if (pktValid && pktHitPort) begin
            // enable bits 4:0 line up with the candidate order of pktHit
            pr = cur_ff.prio[pktIdx];
            avail = pktHit & pr[NUM_SRC-1:0];
            nxt_cur.prioValid = 1'b1;
            nxt_cur.prioOut = resolvePrio(avail, pktCandPrio, pr[PRI_HIGHEST_BIT],
                pr[PRI_OR_BIT], pktDefPrio);
            nxt_cur.monitor = cur_ff.mirror[pktIdx][MIR_RX_BIT];
        end
        // a transmit on an unknown port is never marked as monitored
        if (txValid && txHitPort) begin
            nxt_cur.txMon = cur_ff.mirror[txIdx][MIR_TX_BIT];
        end else if (txValid) begin
            nxt_cur.txMon = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // flags come up high: nothing is pending after reset
            cur_ff <= '0;
            cur_ff.state <= PICR_IDLE;
            cur_ff.wrDone <= {NUM_PORTS{ACL_CTRL_RST[ACL_WR_DONE_BIT]}};
            cur_ff.rdDone <= {NUM_PORTS{ACL_CTRL_RST[ACL_RD_DONE_BIT]}};
            cur_ff.mirror <= {NUM_PORTS{MIRROR_RST}};
            cur_ff.prio <= {NUM_PORTS{PRIO_RST}};
        end else if (ce) begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // entry memory; stage data is sampled in the access cycle, one after start

    assign memWrEn = (cur_ff.state == PICR_ACCESS) && cur_ff.opWrite;
    assign memRdEn = (cur_ff.state == PICR_ACCESS) && !cur_ff.opWrite;
    assign memAddr = AW'({cur_ff.opPort, cur_ff.opIndex});

    picr_entry_mem #(
        .DATA_W(EW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .wrEn(memWrEn),
        .rdEn(memRdEn),
        .addr(memAddr),
        .wrData(aclStageData),
        .byteEn(cur_ff.opByteEn),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign regRdData = cur_ff.rdData;
    assign aclEntryRdData = cur_ff.entryRdData;
    assign aclEntryRdByteEn = cur_ff.entryRdByteEn;
    assign aclEntryRdValid = cur_ff.entryRdValid;
    // busy follows the state, so it falls in the cycle the flag rises
    assign aclBusy = cur_ff.state != PICR_IDLE;
    assign pktPrioValid = cur_ff.prioValid;
    assign pktPrio = cur_ff.prioOut;
    assign pktMonitor = cur_ff.monitor;
    assign txMonitor = cur_ff.txMon;

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            rxSniffEn[p] = cur_ff.mirror[p][MIR_RX_BIT];
            txSniffEn[p] = cur_ff.mirror[p][MIR_TX_BIT];
            snifferPort[p] = cur_ff.mirror[p][MIR_SNIFFER_BIT];
            prioHighestEn[p] = cur_ff.prio[p][PRI_HIGHEST_BIT];
            prioOrEn[p] = cur_ff.prio[p][PRI_OR_BIT];
            macPrioEn[p] = cur_ff.prio[p][PRI_MAC_BIT];
            vlanPrioEn[p] = cur_ff.prio[p][PRI_VLAN_BIT];
            pcpPrioEn[p] = cur_ff.prio[p][PRI_PCP_BIT];
            dscpPrioEn[p] = cur_ff.prio[p][PRI_DSCP_BIT];
            aclPrioEn[p] = cur_ff.prio[p][PRI_ACL_BIT];
        end
    end
endmodule : picr_regs
`default_nettype wire

// >>> verification/picr_regs_asserts.sv
// assertion checker for the per-port ingress control register bank
`timescale 1ns/100ps
`default_nettype none
module picr_regs_asserts
    import picr_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [picr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [picr_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [picr_pkg::DATA_W-1:0] regRdData,
    input wire logic aclEntryRdValid,
    input wire logic aclBusy,
    input wire logic [NUM_PORTS-1:0] rxSniffEn,
    input wire logic [NUM_PORTS-1:0] txSniffEn,
    input wire logic [NUM_PORTS-1:0] snifferPort,
    input wire logic [NUM_PORTS-1:0] prioOrEn,
    input wire logic pktValid,
    input wire logic [1:0] pktPort,
    input wire logic [picr_pkg::NUM_SRC-1:0] pktHit,
    input wire logic [picr_pkg::PRIO_W-1:0] pktDefPrio,
    input wire logic pktPrioValid,
    input wire logic [picr_pkg::PRIO_W-1:0] pktPrio,
    input wire logic pktMonitor,
    input wire logic txValid,
    input wire logic [1:0] txPort,
    input wire logic txMonitor
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic aclStart;
    logic pktTaken;
    logic txTaken;
    // limitation: timing checks assume ce stays high across the operation
    assign aclStart = ce && regWrStb && !aclBusy && regAddr[11:0] == OFF_ACL_BE_LSB
        && regAddr[15:12] != 4'h0 && int'(regAddr[15:12]) <= NUM_PORTS;
    assign pktTaken = ce && pktValid && pktPort != 2'h0 && int'(pktPort) <= NUM_PORTS;
    assign txTaken = ce && txValid && txPort != 2'h0 && int'(txPort) <= NUM_PORTS;
    AST_RD_IDLE_ZERO: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero outside read answer");
    AST_ACL_BUSY: assert property (aclStart |=> aclBusy [*2] ##1 !aclBusy)
        else $error("transfer busy window wrong");
    AST_ACL_VALID: assert property (aclEntryRdValid |-> !aclBusy && $past(aclBusy))
        else $error("entry read result outside transfer end");
    AST_VALID_PULSE: assert property (aclEntryRdValid |=> !aclEntryRdValid)
        else $error("entry read valid longer than one cycle");
    AST_PKT_ANSWER: assert property (pktTaken |=> pktPrioValid)
        else $error("no priority answer after packet");
    AST_PKT_NONE: assert property (!pktTaken |=> !pktPrioValid)
        else $error("priority answer without packet");
    AST_PKT_DEFAULT: assert property (pktTaken && pktHit == 5'h00
        |=> pktPrio == $past(pktDefPrio))
        else $error("default priority not applied");
    AST_RX_MONITOR: assert property (pktTaken
        |=> pktMonitor == $past(rxSniffEn[pktPort - 2'h1]))
        else $error("receive monitor mark wrong");
    AST_TX_MONITOR: assert property (txTaken
        |=> txMonitor == $past(txSniffEn[txPort - 2'h1]))
        else $error("transmit monitor mark wrong");
    AST_MIRROR_WR: assert property (ce && regWrStb && regAddr == 16'h1800
        |=> snifferPort[0] == $past(regWrData[1]) && rxSniffEn[0] == $past(regWrData[6]))
        else $error("mirror control write not applied");
    AST_OR_WR: assert property (ce && regWrStb && regAddr == 16'h1801
        |=> prioOrEn[0] == $past(regWrData[6]))
        else $error("priority control write not applied");
endmodule : picr_regs_asserts
bind picr_regs picr_regs_asserts #(.NUM_PORTS(NUM_PORTS)) i_picr_regs_asserts (.*);
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the per-port ingress control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import picr_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] regAddr = 16'h0000;
    logic [DATA_W-1:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic [7:0] aclByteEnHi = 8'h00;
    logic [ENTRY_BYTES*8-1:0] aclStageData = 128'h0;
    logic [ENTRY_BYTES*8-1:0] aclEntryRdData;
    logic [ENTRY_BYTES-1:0] aclEntryRdByteEn;
    logic aclEntryRdValid, aclBusy, pktPrioValid, pktMonitor, txMonitor;
    logic [2:0] rxSniffEn, txSniffEn, snifferPort, prioHighestEn, prioOrEn;
    logic [2:0] macPrioEn, vlanPrioEn, pcpPrioEn, dscpPrioEn, aclPrioEn;
    logic pktValid = 1'b0;
    logic [1:0] pktPort = 2'h0;
    logic [NUM_SRC-1:0] pktHit = 5'h1F;
    // candidates: acl 1, dscp 3, pcp 6, vlan 2, mac 5; or gives 7, max gives 6
    logic [NUM_SRC-1:0][PRIO_W-1:0] pktCandPrio = 15'h5599;
    logic [PRIO_W-1:0] pktDefPrio = 3'h4;
    logic [PRIO_W-1:0] pktPrio;
    logic txValid = 1'b0;
    logic [1:0] txPort = 2'h0;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    picr_regs #(.NUM_PORTS(3), .ENTRIES(16)) i_picr_regs (.*);

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1;
        chk("regRdData", exp, regRdData);
    endtask : rdchk

    // start on port 1, check flag low mid-transfer, then result and flag back high
    task automatic aclGo(input logic [7:0] be, input logic [7:0] busyExp,
                         input logic [7:0] doneExp, input logic validExp);
        wr(16'h1611, be);
        rdchk(16'h1612, busyExp);
        for (int i = 0; i < 6 && aclEntryRdValid !== 1'b1; i++) @(posedge sys_clk) #1;
        chk("aclEntryRdValid", validExp, aclEntryRdValid);
        rdchk(16'h1612, doneExp);
    endtask : aclGo

    task automatic pkt(input logic [7:0] prio, input logic [2:0] exp);
        wr(16'h3801, prio);
        chk("prioEn", {prio[7:6], prio[4:0]}, {prioHighestEn[2], prioOrEn[2], macPrioEn[2],
            vlanPrioEn[2], pcpPrioEn[2], dscpPrioEn[2], aclPrioEn[2]});
        @(posedge sys_clk);
        pktValid <= 1'b1;
        pktPort <= 2'h3;
        @(posedge sys_clk);
        pktValid <= 1'b0;
        #1;
        chk("pktPrioValid", 1'b1, pktPrioValid);
        chk("pktPrio", exp, pktPrio);
    endtask : pkt

    task automatic txchk(input logic [1:0] port, input logic expMon);
        @(posedge sys_clk);
        txValid <= 1'b1;
        txPort <= port;
        @(posedge sys_clk);
        txValid <= 1'b0;
        #1;
        chk("txMonitor", expMon, txMonitor);
    endtask : txchk

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: the whole sequence needs about 135 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int p = 1; p <= 3; p++) begin
            rdchk({p[3:0], OFF_ACL_CTRL}, ACL_CTRL_RST);
            rdchk({p[3:0], OFF_MIRROR}, MIRROR_RST);
            rdchk({p[3:0], OFF_PRIO}, PRIO_RST);
        end
        $display("test reset_values done");
        wr(16'h1612, 8'hFF);
        wr(16'h2612, 8'h05);
        rdchk(16'h1612, 8'h7F);
        rdchk(16'h2612, 8'h65);
        rdchk(16'h3612, 8'h60);
        wr(16'h1800, 8'hFF);
        rdchk(16'h1800, 8'h62);
        chk("mirror1", 3'h7, {rxSniffEn[0], txSniffEn[0], snifferPort[0]});
        wr(16'h1801, 8'hFF);
        rdchk(16'h1801, 8'hDF);
        rdchk(16'h1700, 8'h00);
        rdchk(16'h0612, 8'h00);
        $display("test register_access done");
        @(posedge sys_clk);
        aclStageData <= 128'h00112233445566778899AABBCCDDEEFF;
        aclByteEnHi <= 8'hFF;
        aclGo(8'hFF, 8'h3F, 8'h7F, 1'b0);
        wr(16'h1612, 8'h0F);
        @(posedge sys_clk);
        aclStageData <= 128'h0;
        aclByteEnHi <= 8'h00;
        aclGo(8'h0F, 8'h4F, 8'h6F, 1'b1);
        chk("aclEntryRdByteEn", 16'h000F, aclEntryRdByteEn);
        chk("aclEntryRdData", 32'hCCDDEEFF, aclEntryRdData[31:0]);
        $display("test acl_transfer done");
        wr(16'h3800, 8'h60);
        pkt(8'h00, 3'h4);
        pkt(8'h01, 3'h1);
        pkt(8'h02, 3'h3);
        pkt(8'h04, 3'h6);
        pkt(8'h08, 3'h2);
        pkt(8'h10, 3'h5);
        pkt(8'h9F, 3'h6);
        pkt(8'h5F, 3'h7);
        chk("pktMonitor", 1'b1, pktMonitor);
        @(posedge sys_clk);
        pktHit <= 5'h00;
        pkt(8'h5F, 3'h4);
        txchk(2'h3, 1'b1);
        txchk(2'h2, 1'b0);
        txchk(2'h0, 1'b0);
        $display("test classification done");
        // reset lands while a read transfer is still running
        wr(16'h1611, 8'h01);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdchk(16'h1612, ACL_CTRL_RST);
        rdchk(16'h3800, MIRROR_RST);
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(16'h1801, 8'h01);
        @(posedge sys_clk);
        ce <= 1'b1;
        rdchk(16'h1801, PRIO_RST);
        chk("aclPrioEn", 1'b0, aclPrioEn[0]);
        $display("test reset_and_enable done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
